// >>> shared/tirq_defines.svh
`ifndef TIRQ_DEFINES_SVH
`define TIRQ_DEFINES_SVH
`define TIRQ_IDX_ENABLE_ONE  16'hfff3
`define TIRQ_IDX_ENABLE_TWO  16'hfff4
`define TIRQ_IDX_REQUEST_ONE 16'hfff6
`define TIRQ_IDX_REQUEST_TWO 16'hfff7
`define TIRQ_IDX_STATUS      16'hfff8
`define TIRQ_IDX_MASK        16'hfff9
`define TIRQ_BYTE_ADDR(i)    {i, 2'b00}
`define TIRQ_EN1_TIMER_A     5
`define TIRQ_RQ1_TIMER_A     7
`define TIRQ_EN2_TIMER_C     1
`define TIRQ_RQ2_TIMER_C     7
`define TIRQ_RESET_BYTE      8'h00
`define TIRQ_RESET_BIT       1'b0
`define TIRQ_STS_ONE         0
`define TIRQ_STS_TWO         1
`endif

// >>> shared/tirq_pkg.sv
package tirq_pkg;
	// per-register source pulses, bit positions match the request registers
	typedef struct packed {
		logic [7:0] one;
		logic [7:0] two;
	} tirq_src_t;
	typedef struct packed {
		logic [7:0] one;
		logic [7:0] two;
	} tirq_pend_t;
	typedef enum logic [2:0] {
		TIRQ_R_EN1, TIRQ_R_EN2, TIRQ_R_RQ1, TIRQ_R_RQ2,
		TIRQ_R_STS, TIRQ_R_MSK, TIRQ_R_NONE
	} tirq_reg_t;
endpackage

// >>> src/tirq_regs.sv
`timescale 1ns/1ns
`default_nettype none
`include "tirq_defines.svh"
module tirq_regs
	import tirq_pkg::*;
(
	input  wire logic        hclk,
	input  wire logic        hresetn,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic      [31:0] hrdata,
	output logic             hreadyout,
	output logic             hresp,
	input  wire tirq_src_t   src,
	output tirq_pend_t       pend,
	output logic             irq
);
	// bus side state
	tirq_reg_t   areg;
	tirq_reg_t   dreg;
	tirq_reg_t   next_dreg;
	logic        dwr;
	logic        next_dwr;
	logic        take;

	// data phase write strobes
	logic        wr_en1;
	logic        wr_en2;
	logic        wr_rq1;
	logic        wr_rq2;
	logic        wr_sts;
	logic        wr_msk;
	logic [7:0]  wbyte;

	// enable and mask registers
	logic [7:0]  en1;
	logic [7:0]  en2;
	logic [7:0]  msk;
	logic [7:0]  next_en1;
	logic [7:0]  next_en2;
	logic [7:0]  next_msk;

	// request flags and status
	logic [7:0]  rq1;
	logic [7:0]  rq2;
	logic [7:0]  sts;
	logic [7:0]  next_rq1;
	logic [7:0]  next_rq2;
	logic [7:0]  next_sts;
	logic [7:0]  sts_set;

	// output side
	logic [7:0]  rdv;
	logic [31:0] next_hrdata;
	tirq_pend_t  next_pend;
	logic        next_irq;
	logic        next_hreadyout;
	logic        next_hresp;

	// address decode: only six word addresses are mapped,
	// everything else reads zero and ignores writes
	always_comb begin
		areg = TIRQ_R_NONE;
		if (haddr[31:18] == 14'h0000) begin
			unique case (haddr[17:0])
			`TIRQ_BYTE_ADDR(`TIRQ_IDX_ENABLE_ONE): begin
				areg = TIRQ_R_EN1;
			end
			`TIRQ_BYTE_ADDR(`TIRQ_IDX_ENABLE_TWO): begin
				areg = TIRQ_R_EN2;
			end
			`TIRQ_BYTE_ADDR(`TIRQ_IDX_REQUEST_ONE): begin
				areg = TIRQ_R_RQ1;
			end
			`TIRQ_BYTE_ADDR(`TIRQ_IDX_REQUEST_TWO): begin
				areg = TIRQ_R_RQ2;
			end
			`TIRQ_BYTE_ADDR(`TIRQ_IDX_STATUS): begin
				areg = TIRQ_R_STS;
			end
			`TIRQ_BYTE_ADDR(`TIRQ_IDX_MASK): begin
				areg = TIRQ_R_MSK;
			end
			default: begin
				areg = TIRQ_R_NONE;
			end
			endcase
		end
	end

	// address phase capture; sub-word writes are dropped since
	// every register is one whole word
	always_comb begin
		take      = hsel && hready && htrans[1];
		next_dreg = TIRQ_R_NONE;
		next_dwr  = 1'b0;
		if (take) begin
			next_dreg = areg;
			next_dwr  = hwrite && (hsize == 3'h2);
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			dreg <= TIRQ_R_NONE;
			dwr  <= 1'b0;
		end else begin
			dreg <= next_dreg;
			dwr  <= next_dwr;
		end
	end

	// one strobe per register during the write data phase
	always_comb begin
		wbyte  = hwdata[7:0];
		wr_en1 = dwr && (dreg == TIRQ_R_EN1);
		wr_en2 = dwr && (dreg == TIRQ_R_EN2);
		wr_rq1 = dwr && (dreg == TIRQ_R_RQ1);
		wr_rq2 = dwr && (dreg == TIRQ_R_RQ2);
		wr_sts = dwr && (dreg == TIRQ_R_STS);
		wr_msk = dwr && (dreg == TIRQ_R_MSK);
	end

	// enables and mask are plain read/write bytes
	always_comb begin
		next_en1 = en1;
		next_en2 = en2;
		next_msk = msk;
		if (wr_en1) begin
			next_en1 = wbyte;
		end
		if (wr_en2) begin
			next_en2 = wbyte;
		end
		if (wr_msk) begin
			next_msk = wbyte;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			en1 <= `TIRQ_RESET_BYTE;
			en2 <= `TIRQ_RESET_BYTE;
			msk <= `TIRQ_RESET_BYTE;
		end else begin
			en1 <= next_en1;
			en2 <= next_en2;
			msk <= next_msk;
		end
	end

	// status bit one gathers every source of the first request
	// register, the next bit every source of the second
	always_comb begin
		sts_set                = 8'h00;
		sts_set[`TIRQ_STS_ONE] = |src.one;
		sts_set[`TIRQ_STS_TWO] = |src.two;
	end

	genvar b;
	generate
		for (b = 0; b < 8; b++) begin : g_bit
			// a source pulse wins over a clear in the same cycle,
			// so an event is never lost to a racing write
			always_comb begin
				next_rq1[b] = rq1[b];
				next_rq2[b] = rq2[b];
				next_sts[b] = sts[b];
				// request flags clear on a written 0
				if (wr_rq1 && !wbyte[b]) begin
					next_rq1[b] = 1'b0;
				end
				if (wr_rq2 && !wbyte[b]) begin
					next_rq2[b] = 1'b0;
				end
				// status clears on a written 1
				if (wr_sts && wbyte[b]) begin
					next_sts[b] = 1'b0;
				end
				if (src.one[b]) begin
					next_rq1[b] = 1'b1;
				end
				if (src.two[b]) begin
					next_rq2[b] = 1'b1;
				end
				if (sts_set[b]) begin
					next_sts[b] = 1'b1;
				end
			end

			always_ff @(posedge hclk or negedge hresetn) begin
				if (!hresetn) begin
					rq1[b] <= `TIRQ_RESET_BIT;
					rq2[b] <= `TIRQ_RESET_BIT;
					sts[b] <= `TIRQ_RESET_BIT;
				end else begin
					rq1[b] <= next_rq1[b];
					rq2[b] <= next_rq2[b];
					sts[b] <= next_sts[b];
				end
			end
		end
	endgenerate

	// read data is taken at the address phase from next-state values,
	// so a write landing on that same edge is already visible and
	// hrdata still comes from a flop with no wait state
	always_comb begin
		unique case (next_dreg)
		TIRQ_R_EN1: begin
			rdv = next_en1;
		end
		TIRQ_R_EN2: begin
			rdv = next_en2;
		end
		TIRQ_R_RQ1: begin
			rdv = next_rq1;
		end
		TIRQ_R_RQ2: begin
			rdv = next_rq2;
		end
		TIRQ_R_STS: begin
			rdv = next_sts;
		end
		TIRQ_R_MSK: begin
			rdv = next_msk;
		end
		TIRQ_R_NONE: begin
			rdv = 8'h00;
		end
		default: begin
			rdv = 8'h00;
		end
		endcase
		next_hrdata = {24'h00_0000, rdv};
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata <= 32'h0000_0000;
		end else begin
			hrdata <= next_hrdata;
		end
	end

	// timer A and timer C keep their enable away from their flag bit;
	// the remaining sources pair flag and enable by position, since
	// their enable layout is not pinned down here
	always_comb begin
		next_pend.one = next_rq1 & next_en1;
		next_pend.two = next_rq2 & next_en2;
		next_pend.one[`TIRQ_RQ1_TIMER_A] =
			next_rq1[`TIRQ_RQ1_TIMER_A] && next_en1[`TIRQ_EN1_TIMER_A];
		next_pend.two[`TIRQ_RQ2_TIMER_C] =
			next_rq2[`TIRQ_RQ2_TIMER_C] && next_en2[`TIRQ_EN2_TIMER_C];
		next_irq = |(next_sts & next_msk);
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pend <= '0;
			irq  <= 1'b0;
		end else begin
			pend <= next_pend;
			irq  <= next_irq;
		end
	end

	// never stalls and never errors, held in flops for clean outputs
	always_comb begin
		next_hreadyout = 1'b1;
		next_hresp     = 1'b0;
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
		end else begin
			hreadyout <= next_hreadyout;
			hresp     <= next_hresp;
		end
	end

	// the bus answers with zero wait states: an address phase
	// taken on one edge has its data phase completed on the next,
	// and a read sees any write that completes on its address edge
endmodule
`default_nettype wire

// >>> verif/tirq_regs_asserts.sv
`timescale 1ns/1ns
`default_nettype none
module tirq_regs_asserts
	import tirq_pkg::*;
(
	input wire logic       hclk,
	input wire logic       hresetn,
	input wire logic [1:0] htrans,
	input wire logic       hwrite,
	input wire logic       hreadyout,
	input wire logic       hresp,
	input wire tirq_src_t  src,
	input wire tirq_pend_t pend,
	input wire logic       irq
);
	// writes and source events of the last three edges
	logic [5:0] h;
	always_ff @(posedge hclk or negedge hresetn)
		if (!hresetn) h <= '0;
		else h <= {h[4:3], htrans[1] & hwrite, h[1:0], |src};
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	a_ready_high: assert property (hreadyout) else $error("wait state");
	a_resp_okay: assert property (!hresp) else $error("bad response");
	a_one_cause: assert property ($rose(|pend.one) |-> |h)
		else $error("pend one rose alone");
	a_two_cause: assert property ($rose(|pend.two) |-> |h)
		else $error("pend two rose alone");
	a_pend_drop: assert property ($fell(|pend) |-> |h[5:3])
		else $error("pend fell alone");
	a_irq_cause: assert property ($rose(irq) |-> |h)
		else $error("irq rose alone");
	a_irq_drop: assert property ($fell(irq) |-> |h[5:3])
		else $error("irq fell alone");
endmodule
`default_nettype wire

// >>> verif/tirq_regs_tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module tirq_regs_tb_top
	import tirq_pkg::*;
;
	logic        hclk = 1'h0, hresetn = 1'h0, hwrite = 1'h0;
	logic        irq, hreadyout, hresp;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, r;
	logic [1:0]  htrans = 2'h0;
	tirq_src_t   src;
	tirq_pend_t  pend;
	int          fail_count = 0, n_compared = 0;
	tirq_regs tirq_regs_i(.hclk, .hresetn, .hsel(1'h1), .haddr, .htrans,
		.hwrite, .hsize(3'h2), .hwdata, .hready(hreadyout), .hrdata,
		.hreadyout, .hresp, .src, .pend, .irq);
	tirq_src_model tirq_src_model_i(.hclk, .src);
	initial forever #50 hclk = ~hclk;
	// registers sit at word indices fff3..fff9; xfer reaches fff0..ffff
	task automatic xfer(input logic w, input logic [3:0] i, [7:0] d);
		htrans <= 2'h2;
		haddr <= {14'h0, 12'hfff, i, 2'h0};
		hwrite <= w;
		do @(posedge hclk); while (hreadyout !== 1'h1);
		htrans <= 2'h0;
		hwdata <= {24'h0, d};
		do @(posedge hclk); while (hreadyout !== 1'h1);
		r = hrdata;
	endtask
	task automatic chk(input logic [31:0] g, e);
		n_compared++;
		if (g !== e) begin
			fail_count++;
			$display("wrong value at %0t: %h not %h", $time, g, e);
		end
	endtask
	task automatic print_verdict;
		$display("%0d compared, %0d wrong", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	initial begin
		#200000;
		fail_count++;
		print_verdict();
	end
	initial begin
		repeat (10) @(posedge hclk);
		hresetn <= 1'h1;
		@(posedge hclk);
		xfer(1'h1, 4'h3, 8'h20);
		xfer(1'h0, 4'h3, 8'h0);
		chk(r, 32'h20);
		tirq_src_model_i.fire(16'h8000);
		xfer(1'h0, 4'h6, 8'h0);
		chk(r, 32'h80);
		chk(32'(pend.one), 32'h80);
		xfer(1'h1, 4'h6, 8'h7f);
		xfer(1'h0, 4'h6, 8'h0);
		chk(r, 32'h0);
		chk(32'(|pend.one), 32'h0);
		$display("test first timer done");
		xfer(1'h1, 4'h4, 8'h02);
		tirq_src_model_i.fire(16'h0080);
		xfer(1'h0, 4'h7, 8'h0);
		chk(r, 32'h80);
		chk(32'(pend.two), 32'h80);
		xfer(1'h1, 4'h4, 8'h0);
		xfer(1'h0, 4'h0, 8'h0);
		chk(r, 32'h0);
		chk(32'(|pend.two), 32'h0);
		$display("test third timer done");
		tirq_src_model_i.fire(16'h4001);
		xfer(1'h0, 4'h6, 8'h0);
		chk(r, 32'h40);
		xfer(1'h0, 4'h7, 8'h0);
		chk(r, 32'h81);
		$display("test other sources done");
		xfer(1'h1, 4'h9, 8'h01);
		xfer(1'h0, 4'h8, 8'h0);
		chk(r, 32'h3);
		chk(32'(irq), 32'h1);
		xfer(1'h1, 4'h8, 8'h01);
		xfer(1'h0, 4'h8, 8'h0);
		chk(r, 32'h2);
		chk(32'(irq), 32'h0);
		$display("test interrupt done");
		print_verdict();
	end
endmodule
bind tirq_regs tirq_regs_asserts tirq_regs_asserts_i(.hclk, .hresetn,
	.htrans, .hwrite, .hreadyout, .hresp, .src, .pend, .irq);
`default_nettype wire

// >>> verif/tirq_src_model.sv
`timescale 1ns/1ns
`default_nettype none
module tirq_src_model
	import tirq_pkg::*;
(
	input  wire logic    hclk,
	output var tirq_src_t src
);
	initial src = '0;
	// one-cycle pulse, like a counter wrap
	task automatic fire(input tirq_src_t p);
		@(posedge hclk) src <= p;
		@(posedge hclk) src <= '0;
	endtask
endmodule
`default_nettype wire
